// *** core/uie_core.sv ***
/*
 Interrupt enable mask, event pending flags and interrupt output of the
 USB device controller. Assumes the mode register supplies the global enable,
 the interrupt configuration register supplies the debug modes, and the
 interrupt reason register clears pending flags through pending_clear.
*/
module uie_core #(
    parameter int NUM_ENDPOINTS = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire uie_pkg::uie_reg_req_t reg_req,
    output logic [31:0] reg_rdata,
    input wire logic global_irq_enable,
    input wire uie_pkg::uie_debug_cfg_t debug_cfg,
    input wire logic [7:0] bus_event,
    input wire uie_pkg::uie_handshake_t handshake,
    input wire logic [31:0] pending_clear,
    output logic [31:0] pending,
    output logic [31:0] irq_enable_mask,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Elaboration check: the bit map holds endpoints 0 to 7 only
    if (NUM_ENDPOINTS < 2 || NUM_ENDPOINTS > uie_pkg::MAX_ENDPOINTS) begin : g_bad_ep
        $error("NUM_ENDPOINTS must lie between 2 and 8");
    end

    // Endpoints numbered NUM_ENDPOINTS and above have no enable bits at all
    localparam int TOP_BIT = uie_pkg::ENDPOINT_BASE_BIT + 2 * (NUM_ENDPOINTS - 1);
    localparam logic [31:0] IMPL_BITS = uie_pkg::MASK_WRITABLE & 32'((64'h1 << TOP_BIT) - 64'h1);

    uie_pkg::uie_state_t s;
    uie_pkg::uie_state_t next_s;
    logic [31:0] ep_raise;
    logic [31:0] next_armed;
    logic [31:0] byte_mask;
    logic wr_hit;
    logic rd_hit;

    ////////////////////////////////////////////////////////////////////////////
    // Per-bit handshake decode and debug-mode qualification
    for (genvar b = 0; b < 32; b++) begin : g_src
        if (b >= uie_pkg::CTRL_SETUP_BIT && b < TOP_BIT && b != uie_pkg::RESERVED_BIT) begin : g_ep
            localparam bit IS_CTRL = b <= uie_pkg::CTRL_IN_BIT;
            localparam int EP_NUM = IS_CTRL ? 0 : (b - uie_pkg::ENDPOINT_BASE_BIT) / 2 + 1;
            localparam bit DIR_IN = IS_CTRL ? (b == uie_pkg::CTRL_IN_BIT) :
                ((b - uie_pkg::ENDPOINT_BASE_BIT) % 2 == 1);
            localparam bit SETUP = b == uie_pkg::CTRL_SETUP_BIT;
            logic match;
            logic ack;
            logic nak;
            uie_pkg::uie_dbg_mode_t mode;
            // Setup packets match only the setup bit; others match on direction
            assign match = handshake.valid && handshake.endpoint == 4'(EP_NUM) &&
                handshake.is_setup == SETUP && (SETUP || handshake.is_in == DIR_IN);
            assign ack = match && !handshake.is_nak;
            assign nak = match && handshake.is_nak;
            // Endpoint 0 always follows the control mode
            assign mode = IS_CTRL ? debug_cfg.control_debug_mode :
                DIR_IN ? debug_cfg.data_in_debug_mode :
                debug_cfg.data_out_debug_mode;
            // Reserved mode behaves as ACK only, the quietest safe choice
            assign ep_raise[b] = ack || (nak && (mode == uie_pkg::UIE_DBG_ACK_NAK ||
                (mode == uie_pkg::UIE_DBG_ACK_FIRST_NAK && s.nak_armed[b])));
            // An ACK re-arms the first-NAK report
            assign next_armed[b] = ack ? 1'b1 :
                (nak && mode == uie_pkg::UIE_DBG_ACK_FIRST_NAK) ? 1'b0 : s.nak_armed[b];
        end else begin : g_none
            assign ep_raise[b] = 1'b0;
            assign next_armed[b] = s.nak_armed[b];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register decode
    assign wr_hit = reg_req.write && reg_req.addr == uie_pkg::IRQ_ENABLE_ADDR;
    assign rd_hit = reg_req.read && reg_req.addr == uie_pkg::IRQ_ENABLE_ADDR;
    assign byte_mask = {{8{reg_req.byte_en[3]}}, {8{reg_req.byte_en[2]}},
        {8{reg_req.byte_en[1]}}, {8{reg_req.byte_en[0]}}};

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_s = s;
        next_s.nak_armed = next_armed;
        // Host write touches enabled lanes of implemented bits only
        if (wr_hit) begin
            next_s.mask = (s.mask & ~(byte_mask & IMPL_BITS)) |
                (reg_req.wdata & byte_mask & IMPL_BITS);
        end
        // Bus reset wins over a write in the same cycle
        if (bus_event[uie_pkg::BUS_RESET_BIT]) begin
            next_s.mask = uie_pkg::MASK_AFTER_BUS_RESET;
            next_s.nak_armed = uie_pkg::NAK_ARMED_RESET;
        end
        // Set beats clear so an event in the clear cycle is kept
        next_s.pending = ((s.pending & ~pending_clear) | ep_raise |
            {24'h00_0000, bus_event}) & IMPL_BITS;
        // Output gate on the current flags; one cycle behind the pending flop
        next_s.irq = global_irq_enable && |(s.pending & s.mask);
        // Read data stands for the one cycle after the read strobe
        next_s.rdata = rd_hit ? s.mask : uie_pkg::READ_IDLE;
    end

    // State register, synchronous reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s.mask <= uie_pkg::MASK_RESET;
            s.pending <= uie_pkg::PENDING_RESET;
            s.nak_armed <= uie_pkg::NAK_ARMED_RESET;
            s.rdata <= uie_pkg::READ_IDLE;
            s.irq <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    // Every output is a state flop, never a gate
    assign reg_rdata = s.rdata;
    assign pending = s.pending;
    assign irq_enable_mask = s.mask;
    assign irq = s.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    property p_power_on_clear;
        disable iff (1'b0)
        !rst_n |=> irq_enable_mask == uie_pkg::MASK_RESET && !irq;
    endproperty
    a_power_on_clear: assert property (p_power_on_clear)
        else $error("mask not cleared by reset");

    property p_reserved_zero;
        (irq_enable_mask & ~IMPL_BITS) == 32'h0000_0000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved mask bit set");

    property p_bus_reset_mask;
        bus_event[0] |=> irq_enable_mask == uie_pkg::MASK_AFTER_BUS_RESET && pending[0];
    endproperty
    a_bus_reset_mask: assert property (p_bus_reset_mask)
        else $error("bus reset did not force the mask");

    property p_full_write;
        wr_hit && reg_req.byte_en == 4'hf && !bus_event[0]
            |=> irq_enable_mask == ($past(reg_req.wdata) & IMPL_BITS);
    endproperty
    a_full_write: assert property (p_full_write)
        else $error("mask write lost");

    property p_mask_holds;
        !wr_hit && !bus_event[0] |=> $stable(irq_enable_mask);
    endproperty
    a_mask_holds: assert property (p_mask_holds)
        else $error("mask changed without cause");

    property p_read_back;
        rd_hit |=> reg_rdata == $past(irq_enable_mask);
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("read data wrong");

    property p_global_off;
        !global_irq_enable |=> !irq;
    endproperty
    a_global_off: assert property (p_global_off)
        else $error("interrupt with global enable low");

    property p_irq_cause;
        irq |-> $past(global_irq_enable) && ($past(pending) & $past(irq_enable_mask)) != 0;
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without enabled pending event");

    property p_irq_follows;
        global_irq_enable && (pending & irq_enable_mask) != 0 |=> irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("interrupt missing");

    property p_bus_events;
        bus_event != 8'h00 |=> (pending[7:0] & $past(bus_event)) == $past(bus_event);
    endproperty
    a_bus_events: assert property (p_bus_events)
        else $error("bus event not latched");

    property p_setup_ack;
        handshake.valid && !handshake.is_nak && handshake.is_setup &&
            handshake.endpoint == 4'h0 |=> pending[8];
    endproperty
    a_setup_ack: assert property (p_setup_ack)
        else $error("setup event lost");

    property p_ctrl_in_ack;
        handshake.valid && !handshake.is_nak && !handshake.is_setup &&
            handshake.endpoint == 4'h0 && handshake.is_in |=> pending[11] &&
            (!pending[10] || $past(pending[10]));
    endproperty
    a_ctrl_in_ack: assert property (p_ctrl_in_ack)
        else $error("control IN event misrouted");

    property p_ep7_tx_ack;
        handshake.valid && !handshake.is_nak && !handshake.is_setup &&
            handshake.endpoint == 4'h7 && handshake.is_in |=> pending[25];
    endproperty
    a_ep7_tx_ack: assert property (p_ep7_tx_ack)
        else $error("endpoint 7 transmit event lost");

    property p_out_ack_only;
        handshake.valid && handshake.is_nak && !handshake.is_setup &&
            handshake.endpoint == 4'h2 && !handshake.is_in && !pending[14] &&
            debug_cfg.data_out_debug_mode == uie_pkg::UIE_DBG_ACK_ONLY |=> !pending[14];
    endproperty
    a_out_ack_only: assert property (p_out_ack_only)
        else $error("NAK raised event in ACK-only mode");

    property p_set_beats_clear;
        bus_event[7] && pending_clear[7] |=> pending[7];
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear)
        else $error("event lost against clear");

    ////////////////////////////////////////////////////////////////////////////
    // Flag, read port, mask write, interrupt output and debug-mode checks

    // Read data falls back to zero once the strobe is gone
    property p_rdata_idle;
        !rd_hit |=> reg_rdata == uie_pkg::READ_IDLE;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data left standing");

    // Reset also clears the flags and the read port
    property p_reset_flags;
        disable iff (1'b0)
        !rst_n |=> pending == uie_pkg::PENDING_RESET && reg_rdata == uie_pkg::READ_IDLE;
    endproperty
    a_reset_flags: assert property (p_reset_flags)
        else $error("flags not cleared by reset");

    // No flag exists where no source exists
    property p_pending_reserved;
        (pending & ~IMPL_BITS) == 32'h0000_0000;
    endproperty
    a_pending_reserved: assert property (p_pending_reserved)
        else $error("reserved pending flag set");

    // Flags are sticky: only a clear strobe takes one down
    property p_pending_sticky;
        pending_clear == 32'h0000_0000 |=> ($past(pending) & ~pending) == 32'h0000_0000;
    endproperty
    a_pending_sticky: assert property (p_pending_sticky)
        else $error("pending flag lost without clear");

    // No flag rises while the engine and the bus are quiet
    property p_no_stray_pending;
        !handshake.valid && bus_event == 8'h00 |=>
            (pending & ~$past(pending)) == 32'h0000_0000;
    endproperty
    a_no_stray_pending: assert property (p_no_stray_pending)
        else $error("pending flag without event");

    // A set-up token belongs to endpoint 0 only
    property p_setup_other_ep;
        handshake.valid && handshake.is_setup && handshake.endpoint != 4'h0 &&
            bus_event == 8'h00 |=> (pending & ~$past(pending)) == 32'h0000_0000;
    endproperty
    a_setup_other_ep: assert property (p_setup_other_ep)
        else $error("set-up event on a data endpoint");

    // ACK and NAK mode reports every data OUT NAK
    property p_out_nak_all;
        handshake.valid && handshake.is_nak && !handshake.is_setup &&
            handshake.endpoint == 4'h2 && !handshake.is_in &&
            debug_cfg.data_out_debug_mode == uie_pkg::UIE_DBG_ACK_NAK |=> pending[14];
    endproperty
    a_out_nak_all: assert property (p_out_nak_all)
        else $error("NAK lost in ACK and NAK mode");

    // Data IN follows its own field, not the data OUT one
    property p_in_ack_only;
        handshake.valid && handshake.is_nak && !handshake.is_setup &&
            handshake.endpoint == 4'h2 && handshake.is_in && !pending[15] &&
            debug_cfg.data_in_debug_mode == uie_pkg::UIE_DBG_ACK_ONLY |=> !pending[15];
    endproperty
    a_in_ack_only: assert property (p_in_ack_only)
        else $error("data IN NAK raised event in ACK-only mode");

    // Endpoint 0 follows the control field even for plain OUT data
    property p_ctrl_ack_only;
        handshake.valid && handshake.is_nak && !handshake.is_setup &&
            handshake.endpoint == 4'h0 && !handshake.is_in && !pending[10] &&
            debug_cfg.control_debug_mode == uie_pkg::UIE_DBG_ACK_ONLY |=> !pending[10];
    endproperty
    a_ctrl_ack_only: assert property (p_ctrl_ack_only)
        else $error("control NAK raised event in ACK-only mode");

    // Once the first NAK has been reported, later NAKs stay quiet
    property p_first_nak_once;
        handshake.valid && handshake.is_nak && !handshake.is_setup &&
            handshake.endpoint == 4'h3 && handshake.is_in && !pending[17] &&
            debug_cfg.data_in_debug_mode == uie_pkg::UIE_DBG_ACK_FIRST_NAK &&
            !s.nak_armed[17] |=> !pending[17];
    endproperty
    a_first_nak_once: assert property (p_first_nak_once)
        else $error("repeated NAK raised event");

    // A lane write leaves the unselected lanes alone
    property p_lane_keep;
        wr_hit && !bus_event[0] |=>
            ((irq_enable_mask ^ $past(irq_enable_mask)) & ~$past(byte_mask)) == 32'h0000_0000;
    endproperty
    a_lane_keep: assert property (p_lane_keep)
        else $error("unselected mask lane changed");

    // Bus reset re-arms every first-NAK report
    property p_bus_reset_rearm;
        bus_event[0] |=> s.nak_armed == uie_pkg::NAK_ARMED_RESET;
    endproperty
    a_bus_reset_rearm: assert property (p_bus_reset_rearm)
        else $error("first-NAK report not re-armed");

    // A masked source never raises the output
    property p_irq_masked;
        (pending & irq_enable_mask) == 32'h0000_0000 |=> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("interrupt from a masked source");

    // Main scenarios the bench should reach
    c_irq_raised: cover property (handshake.valid ##1 pending != 0 ##1 irq);
    c_bus_reset: cover property (wr_hit ##1 bus_event[0]);
    c_first_nak: cover property (handshake.valid && handshake.is_nak &&
        debug_cfg.data_in_debug_mode == uie_pkg::UIE_DBG_ACK_FIRST_NAK);
    c_set_vs_clear: cover property (bus_event[7] && pending_clear[7]);
    c_read_hit: cover property (rd_hit ##1 reg_rdata != 32'h0000_0000);

endmodule

// *** core/uie_pkg.sv ***
/*
 Constants, field positions and carrier types for the USB device interrupt
 enable block. Assumes one core clock domain and a sync active-low reset.
*/
package uie_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map and field positions
    localparam logic [7:0] IRQ_ENABLE_ADDR = 8'h14;
    localparam int BUS_RESET_BIT = 0;
    localparam int FRAME_START_BIT = 1;
    localparam int PSEUDO_FRAME_BIT = 2;
    localparam int SUSPEND_BIT = 3;
    localparam int RESUME_BIT = 4;
    localparam int HIGHSPEED_BIT = 5;
    localparam int DMA_REASON_BIT = 6;
    localparam int VBUS_SENSE_BIT = 7;
    localparam int CTRL_SETUP_BIT = 8;
    localparam int RESERVED_BIT = 9;
    localparam int CTRL_OUT_BIT = 10;
    localparam int CTRL_IN_BIT = 11;
    localparam int ENDPOINT_BASE_BIT = 12;
    localparam int BUS_EVENT_W = 8;
    localparam int MAX_ENDPOINTS = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and writable bits
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [31:0] MASK_AFTER_BUS_RESET = 32'h0000_0001;
    localparam logic [31:0] MASK_WRITABLE = 32'h03ff_fdff;
    localparam logic [31:0] PENDING_RESET = 32'h0000_0000;
    localparam logic [31:0] NAK_ARMED_RESET = 32'hffff_ffff;
    localparam logic [31:0] READ_IDLE = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Debug modes: which handshakes raise an endpoint event
    typedef enum logic [1:0] {
        UIE_DBG_ACK_NAK = 2'b00,
        UIE_DBG_ACK_ONLY = 2'b01,
        UIE_DBG_ACK_FIRST_NAK = 2'b10,
        UIE_DBG_RESERVED = 2'b11
    } uie_dbg_mode_t;

    typedef struct packed {
        uie_dbg_mode_t control_debug_mode;
        uie_dbg_mode_t data_in_debug_mode;
        uie_dbg_mode_t data_out_debug_mode;
    } uie_debug_cfg_t;

    // One handshake report from the serial interface engine
    typedef struct packed {
        logic valid;
        logic [3:0] endpoint;
        logic is_in;
        logic is_setup;
        logic is_nak;
    } uie_handshake_t;

    // Parallel register access from the host microcontroller
    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } uie_reg_req_t;

    typedef struct packed {
        logic [31:0] mask;
        logic [31:0] pending;
        logic [31:0] nak_armed;
        logic [31:0] rdata;
        logic irq;
    } uie_state_t;

endpackage

// *** tb/uie_host_model.sv ***
/*
 Host microcontroller model: one-cycle write and read strobes on the parallel
 register port. Assumes calls start just after a falling clock edge.
*/
module uie_host_model (
    input wire logic clock,
    output uie_pkg::uie_reg_req_t reg_req,
    input wire logic [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial reg_req = '0;

    ////////////////////////////////////////////////////////////////////////////
    // Released lanes show inverted values, so a stale value never looks valid
    // A quiet cycle after each access keeps two calls from driving one step
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        reg_req = '{1'b1, 1'b0, a, be, d};
        @(negedge clock);
        reg_req = '{1'b0, 1'b0, ~a, 4'h0, ~d};
        @(negedge clock);
    endtask

    // Read data is registered, so it is taken one cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_req = '{1'b0, 1'b1, a, 4'h0, 32'h0};
        @(negedge clock);
        reg_req = '{1'b0, 1'b0, ~a, 4'h0, 32'hffff_ffff};
        d = reg_rdata;
        @(negedge clock);
    endtask
endmodule

// *** tb/tb_uie_core.sv ***
/*
 Self-checking bench for the interrupt enable block. Assumes the host model
 drives the register port and this module plays the engine and mode register.
*/
module tb_uie_core;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock = 1'b0;
    logic rst_n = 1'b0;
    wire uie_pkg::uie_reg_req_t reg_req;
    logic [31:0] reg_rdata, pending, irq_enable_mask, rd, exp;
    logic [31:0] pending_clear = 32'h0;
    logic global_irq_enable = 1'b0;
    logic irq;
    uie_pkg::uie_debug_cfg_t debug_cfg = 6'h00;
    logic [7:0] bus_event = 8'h00;
    uie_pkg::uie_handshake_t hs = 8'h00;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 clock = ~clock;

    uie_core #(.NUM_ENDPOINTS(8)) i_uie_core (.clock(clock), .rst_n(rst_n),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .global_irq_enable(global_irq_enable),
        .debug_cfg(debug_cfg), .bus_event(bus_event), .handshake(hs),
        .pending_clear(pending_clear), .pending(pending),
        .irq_enable_mask(irq_enable_mask), .irq(irq));
    uie_host_model i_uie_host_model (.clock(clock), .reg_req(reg_req), .reg_rdata(reg_rdata));

    ////////////////////////////////////////////////////////////////////////////
    // Checking and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Ceiling well above the roughly 185 cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles >= 3000) begin
            error_cnt++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event stimulus: one-cycle pulses, pending flags then visible
    task automatic fire(input logic [7:0] ev, input uie_pkg::uie_handshake_t h);
        bus_event = ev;
        hs = h;
        @(negedge clock);
        bus_event = 8'h00;
        hs = 8'h00;
    endtask

    task automatic clr();
        pending_clear = 32'hffff_ffff;
        @(negedge clock);
        pending_clear = 32'h0;
        @(negedge clock);
    endtask

    // Handshake on endpoint ep, direction in, nak flag, then compare pending
    task automatic shake(input int ep, input logic in, input logic nak, input logic [31:0] w);
        fire(8'h00, '{1'b1, ep[3:0], in, 1'b0, nak});
        chk(pending, w);
        clr();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        chk(irq_enable_mask, 32'h0);
        i_uie_host_model.rd(8'h14, rd);
        chk(rd, 32'h0);
        i_uie_host_model.wr(8'h14, 4'hf, 32'hffff_ffff);
        chk(irq_enable_mask, 32'h03ff_fdff);
        i_uie_host_model.rd(8'h14, rd);
        chk(rd, 32'h03ff_fdff);
        chk(reg_rdata, 32'h0);
        i_uie_host_model.wr(8'h14, 4'h2, 32'h0);
        chk(irq_enable_mask, 32'h03ff_00ff);
        i_uie_host_model.wr(8'h18, 4'hf, 32'h0);
        chk(irq_enable_mask, 32'h03ff_00ff);
        i_uie_host_model.rd(8'h18, rd);
        chk(rd, 32'h0);
        $display("test registers done");

        // Bus events 1 to 7 each set their own flag; irq follows mask and global enable
        global_irq_enable = 1'b1;
        for (int i = 1; i < 8; i++) begin
            fire(8'h01 << i, 8'h00);
            chk(pending, 32'h1 << i);
            @(negedge clock);
            chk({31'h0, irq}, 32'h1);
            clr();
            chk({31'h0, irq}, 32'h0);
        end
        // Event and clear in one cycle: the event must survive
        pending_clear = 32'hffff_ffff;
        fire(8'h80, 8'h00);
        chk(pending, 32'h80);
        @(negedge clock);
        pending_clear = 32'h0;
        @(negedge clock);
        fire(8'h02, 8'h00);
        global_irq_enable = 1'b0;
        @(negedge clock);
        @(negedge clock);
        chk({31'h0, irq}, 32'h0);
        global_irq_enable = 1'b1;
        i_uie_host_model.wr(8'h14, 4'h1, 32'h0);
        @(negedge clock);
        chk({31'h0, irq}, 32'h0);
        clr();
        $display("test bus events done");

        // Each endpoint direction maps to its own flag
        for (int ep = 0; ep < 8; ep++) begin
            for (int d = 0; d < 2; d++) begin
                exp = (ep == 0) ? (32'h400 << d) : (32'h1000 << (2 * (ep - 1) + d));
                shake(ep, d[0], 1'b0, exp);
            end
        end
        fire(8'h00, '{1'b1, 4'h0, 1'b0, 1'b1, 1'b0});
        chk(pending, 32'h100);
        clr();
        fire(8'h00, '{1'b1, 4'h1, 1'b0, 1'b1, 1'b0});
        chk(pending, 32'h0);
        clr();
        fire(8'h00, '{1'b1, 4'h9, 1'b0, 1'b0, 1'b0});
        chk(pending, 32'h0);
        i_uie_host_model.wr(8'h14, 4'hf, 32'h0000_1000);
        fire(8'h00, '{1'b1, 4'h1, 1'b1, 1'b0, 1'b0});
        @(negedge clock);
        chk({31'h0, irq}, 32'h0);
        clr();
        $display("test endpoints done");

        // All four debug codes on the data OUT field
        for (int m = 0; m < 4; m++) begin
            debug_cfg = {4'h0, m[1:0]};
            shake(2, 1'b0, 1'b0, 32'h4000);
            shake(2, 1'b0, 1'b1, (m == 0 || m == 2) ? 32'h4000 : 32'h0);
            shake(2, 1'b0, 1'b1, (m == 0) ? 32'h4000 : 32'h0);
        end
        shake(2, 1'b1, 1'b1, 32'h8000);
        debug_cfg = 6'h04;
        shake(2, 1'b1, 1'b1, 32'h0);
        shake(2, 1'b0, 1'b1, 32'h4000);
        debug_cfg = 6'h08;
        shake(3, 1'b1, 1'b1, 32'h0002_0000);
        shake(3, 1'b1, 1'b1, 32'h0);
        debug_cfg = 6'h10;
        shake(0, 1'b0, 1'b1, 32'h0);
        shake(1, 1'b0, 1'b1, 32'h1000);
        debug_cfg = 6'h00;
        $display("test debug modes done");

        // Bus reset keeps only its own enable
        i_uie_host_model.wr(8'h14, 4'hf, 32'hffff_ffff);
        fire(8'h01, 8'h00);
        chk(irq_enable_mask, 32'h1);
        chk(pending, 32'h1);
        @(negedge clock);
        chk({31'h0, irq}, 32'h1);
        clr();
        // A write in the bus reset cycle loses to the reset
        fork
            i_uie_host_model.wr(8'h14, 4'hf, 32'hffff_ffff);
            fire(8'h01, 8'h00);
        join
        chk(irq_enable_mask, 32'h1);
        clr();
        $display("test bus reset done");
        end_sim();
    end
endmodule
